// ==== smbus_block_register_port.sv ====
// SMBus target port with indexed block access and the output enable register.
`timescale 1ns/1ps
// What this block does
// RULE_01: A write starts with a start and our address with write direction, which we acknowledge.
// RULE_02: After the address the host sends the start index N, which we acknowledge.
// RULE_03: In a block write a byte count follows the index and we acknowledge it.
// RULE_04: In a block write the data bytes go to registers N onward and each is acknowledged.
// RULE_05: The host ends a block write with a stop after the last acknowledged byte.
// RULE_06: A block read uses a repeated start and our address with read direction, acknowledged.
// RULE_07: A block read returns the byte count first, then registers from index N onward.
// RULE_08: The host acknowledges the count and each data byte except the last.
// RULE_09: The host answers the last read byte with a not-acknowledge and then a stop.
// RULE_10: Our target address comes from the latched state of the address strap.
// RULE_11: Output enable bits 1 and 2 gate the two differential outputs and reset to one.
// RULE_12: The register index advances by one after each acknowledged data byte of a block.
// RULE_13: The strap is sampled once at the first power good and then held.
module smbus_block_register_port #(
    parameter logic [6:0] ADDR_SEL0 = smbus_port_pkg::ADDR_SEL0_DEFAULT,
    parameter logic [6:0] ADDR_SEL1 = smbus_port_pkg::ADDR_SEL1_DEFAULT
) (
    // Core clock and reset.
    input wire logic core_clk,
    input wire logic rst_b,
    // SMBus link.
    input wire logic smbClk,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe_b,
    // Straps and power good.
    input wire logic addressStrapSelect,
    input wire logic powerGood,
    // Differential output gates.
    output logic diffOut0Enable,
    output logic diffOut1Enable
);

    typedef struct packed {
        logic sclS1;
        logic sclS2;
        logic sclD;
        logic sdaS1;
        logic sdaS2;
        logic sdaD;
        logic tglS1;
        logic tglS2;
        logic tglD;
        logic pgS1;
        logic pgS2;
        logic pgD;
        logic strapS1;
        logic strapS2;
        logic strapDone;
        logic strapVal;
        smbus_port_pkg::phase_t phase;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic sending;
        logic hostAck;
        logic [7:0] regIndex;
        logic [smbus_port_pkg::REG_COUNT-1:0][7:0] regs;
        logic sdaOut;
        logic sdaOe_b;
        logic oe0;
        logic oe1;
    } core_t;

    typedef struct packed {
        logic linkBit;
        logic linkTgl;
    } link_t;

    localparam core_t CORE_RESET = '{
        phase: smbus_port_pkg::IDLE,
        regs: smbus_port_pkg::REGS_RESET,
        sdaOe_b: 1'b1,
        oe0: 1'b1,
        oe1: 1'b1,
        default: '0
    };

    core_t q;
    core_t next_q;
    link_t lk;
    link_t next_lk;

    logic riseEvt;
    logic fallEvt;
    logic startEvt;
    logic stopEvt;
    logic byteDone;
    logic [6:0] devAddr;

    function automatic logic [7:0] readReg(
        input logic [smbus_port_pkg::REG_COUNT-1:0][7:0] r,
        input logic [7:0] idx
    );
        if (idx < 8'(smbus_port_pkg::REG_COUNT)) begin
            return r[idx[2:0]];
        end
        return 8'hff;
    endfunction : readReg

    // Link domain: each rising edge of the link clock captures one data bit.
    always_comb begin
        next_lk = lk;
        next_lk.linkBit = sdaIn;
        next_lk.linkTgl = ~lk.linkTgl;
    end

    always_ff @(posedge smbClk or negedge rst_b) begin
        if (!rst_b) begin
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    // Core domain events from the synchronised link.
    assign riseEvt = q.tglS2 != q.tglD;
    assign fallEvt = q.sclD & ~q.sclS2;
    assign startEvt = q.sclS2 & q.sclD & q.sdaD & ~q.sdaS2;
    assign stopEvt = q.sclS2 & q.sclD & ~q.sdaD & q.sdaS2;
    assign byteDone = fallEvt && q.bitCnt == smbus_port_pkg::DATA_BITS && !q.sending;
    assign devAddr = q.strapVal ? ADDR_SEL1 : ADDR_SEL0; // see RULE_10

    always_comb begin
        next_q = q;
        next_q.sclS1 = smbClk;
        next_q.sclS2 = q.sclS1;
        next_q.sclD = q.sclS2;
        next_q.sdaS1 = sdaIn;
        next_q.sdaS2 = q.sdaS1;
        next_q.sdaD = q.sdaS2;
        next_q.tglS1 = lk.linkTgl;
        next_q.tglS2 = q.tglS1;
        next_q.tglD = q.tglS2;
        next_q.pgS1 = powerGood;
        next_q.pgS2 = q.pgS1;
        next_q.pgD = q.pgS2;
        next_q.strapS1 = addressStrapSelect;
        next_q.strapS2 = q.strapS1;
        // The strap is caught once at the first power good and kept.
        if (q.pgS2 && !q.pgD && !q.strapDone) begin
            next_q.strapDone = 1'b1; // see RULE_13
            next_q.strapVal = q.strapS2; // see RULE_10
        end
        if (startEvt) begin
            next_q.phase = smbus_port_pkg::ADDR;
            next_q.bitCnt = '0;
            next_q.sending = 1'b0;
            next_q.sdaOe_b = 1'b1;
        end else if (stopEvt) begin
            next_q.phase = smbus_port_pkg::IDLE; // see RULE_05
            next_q.bitCnt = '0;
            next_q.sending = 1'b0;
            next_q.sdaOe_b = 1'b1;
        end else if (riseEvt) begin
            if (q.bitCnt < smbus_port_pkg::ACK_SLOT) begin
                next_q.bitCnt = q.bitCnt + 4'h1;
            end
            if (!q.sending && q.bitCnt < smbus_port_pkg::DATA_BITS) begin
                next_q.shift = {q.shift[6:0], lk.linkBit};
            end
            if (q.sending && q.bitCnt == smbus_port_pkg::DATA_BITS) begin
                next_q.hostAck = ~lk.linkBit; // see RULE_08
            end
        end else if (fallEvt && q.phase != smbus_port_pkg::IDLE) begin
            if (q.bitCnt == smbus_port_pkg::DATA_BITS) begin
                next_q.sdaOe_b = 1'b1;
                if (!q.sending) begin
                    next_q.sdaOe_b = 1'b0;
                    case (q.phase)
                        smbus_port_pkg::ADDR: begin
                            if (q.strapDone && q.shift[7:1] == devAddr) begin
                                // see RULE_01 and RULE_06
                                next_q.phase = q.shift[0] ? smbus_port_pkg::RCOUNT
                                                          : smbus_port_pkg::INDEX;
                            end else begin
                                next_q.sdaOe_b = 1'b1;
                                next_q.phase = smbus_port_pkg::SKIP;
                            end
                        end
                        smbus_port_pkg::INDEX: begin
                            next_q.regIndex = q.shift; // see RULE_02
                            next_q.phase = smbus_port_pkg::WCOUNT;
                        end
                        smbus_port_pkg::WCOUNT: begin
                            next_q.phase = smbus_port_pkg::WDATA; // see RULE_03
                        end
                        smbus_port_pkg::WDATA: begin
                            if (q.regIndex == smbus_port_pkg::OE_REG_IDX) begin
                                next_q.regs[0] = (q.regs[0] & ~smbus_port_pkg::OE_WMASK)
                                    | (q.shift & smbus_port_pkg::OE_WMASK); // see RULE_11
                            end else if (q.regIndex < 8'(smbus_port_pkg::REG_COUNT)) begin
                                next_q.regs[q.regIndex[2:0]] = q.shift; // see RULE_04
                            end
                            next_q.regIndex = q.regIndex + 8'h01; // see RULE_12
                        end
                        default: begin
                            next_q.sdaOe_b = 1'b1;
                        end
                    endcase
                end
            end else if (q.bitCnt == smbus_port_pkg::ACK_SLOT) begin
                next_q.bitCnt = '0;
                next_q.sdaOe_b = 1'b1;
                if (q.phase == smbus_port_pkg::RCOUNT && !q.sending) begin
                    // The count byte leads every block read.
                    next_q.sending = 1'b1;
                    next_q.shift = q.regs[smbus_port_pkg::BYTE_COUNT_IDX[2:0]]; // see RULE_07
                end else if (q.sending && q.hostAck) begin
                    if (q.phase == smbus_port_pkg::RCOUNT) begin
                        next_q.phase = smbus_port_pkg::RDATA;
                        next_q.shift = readReg(q.regs, q.regIndex); // see RULE_07
                    end else begin
                        next_q.regIndex = q.regIndex + 8'h01; // see RULE_12
                        next_q.shift = readReg(q.regs, q.regIndex + 8'h01);
                    end
                end else if (q.sending) begin
                    next_q.sending = 1'b0; // see RULE_09
                    next_q.phase = smbus_port_pkg::SKIP;
                end
                if (next_q.sending) begin
                    next_q.sdaOe_b = next_q.shift[7];
                end
            end else if (q.sending && q.bitCnt != 4'h0) begin
                next_q.shift = {q.shift[6:0], 1'b1};
                next_q.sdaOe_b = q.shift[6];
            end
        end
        next_q.oe0 = next_q.regs[0][smbus_port_pkg::OE0_BIT]; // see RULE_11
        next_q.oe1 = next_q.regs[0][smbus_port_pkg::OE1_BIT]; // see RULE_11
        next_q.sdaOut = 1'b0;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= CORE_RESET;
        end else begin
            q <= next_q;
        end
    end

    assign sdaOut = q.sdaOut;
    assign sdaOe_b = q.sdaOe_b;
    assign diffOut0Enable = q.oe0;
    assign diffOut1Enable = q.oe1;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    AST_ADDR_ACK: assert property ( // see RULE_01
        byteDone && q.phase == smbus_port_pkg::ADDR && q.strapDone
        && q.shift[7:1] == devAddr && !q.shift[0]
        |=> !q.sdaOe_b && q.phase == smbus_port_pkg::INDEX)
        else $error("Write address not acknowledged.");

    AST_FOREIGN_ADDR: assert property ( // see RULE_10
        byteDone && q.phase == smbus_port_pkg::ADDR && q.shift[7:1] != devAddr
        |=> q.sdaOe_b && q.phase == smbus_port_pkg::SKIP)
        else $error("Foreign address was acknowledged.");

    AST_INDEX_ACK: assert property ( // see RULE_02
        byteDone && q.phase == smbus_port_pkg::INDEX
        |=> !q.sdaOe_b && q.regIndex == $past(q.shift))
        else $error("Index byte not taken.");

    AST_COUNT_ACK: assert property ( // see RULE_03
        byteDone && q.phase == smbus_port_pkg::WCOUNT
        |=> !q.sdaOe_b && q.phase == smbus_port_pkg::WDATA)
        else $error("Count byte not acknowledged.");

    AST_WRITE_DATA: assert property ( // see RULE_04
        byteDone && q.phase == smbus_port_pkg::WDATA && q.regIndex == 8'h01
        |=> !q.sdaOe_b && q.regs[1] == $past(q.shift))
        else $error("Data byte not written.");

    AST_INDEX_STEP: assert property ( // see RULE_12
        byteDone && q.phase == smbus_port_pkg::WDATA
        |=> q.regIndex == $past(q.regIndex) + 8'h01)
        else $error("Index did not advance.");

    AST_READ_ADDR: assert property ( // see RULE_06
        byteDone && q.phase == smbus_port_pkg::ADDR && q.strapDone
        && q.shift[7:1] == devAddr && q.shift[0]
        |=> !q.sdaOe_b && q.phase == smbus_port_pkg::RCOUNT)
        else $error("Read address not acknowledged.");

    AST_READ_COUNT: assert property ( // see RULE_07
        fallEvt && q.bitCnt == smbus_port_pkg::ACK_SLOT && !q.sending
        && q.phase == smbus_port_pkg::RCOUNT
        |=> q.sending && q.shift == q.regs[7] && q.sdaOe_b == q.shift[7])
        else $error("Count byte not sent first.");

    AST_OE_GATE: assert property ( // see RULE_11
        byteDone && q.phase == smbus_port_pkg::WDATA && q.regIndex == 8'h00
        |=> diffOut1Enable == $past(q.shift[2]) && diffOut0Enable == $past(q.shift[1]))
        else $error("Output enable not applied.");

    AST_STRAP_HOLD: assert property ( // see RULE_13
        q.strapDone |=> q.strapDone && $stable(q.strapVal))
        else $error("Strap latch changed.");

    AST_LINK_TOGGLE: assert property (@(posedge smbClk) disable iff (!rst_b)
        1'b1 |=> lk.linkTgl != $past(lk.linkTgl))
        else $error("Link bit toggle stalled.");

    COV_WRITE: cover property (byteDone && q.phase == smbus_port_pkg::WDATA);
    COV_READ: cover property (q.phase == smbus_port_pkg::RDATA && fallEvt);
    COV_NACK: cover property (q.sending ##1 q.phase == smbus_port_pkg::SKIP);
    COV_START: cover property (startEvt);

endmodule : smbus_block_register_port

// ==== smbus_block_register_port_bench.sv ====
// Self-checking testbench of the SMBus block register port.
`timescale 1ns/1ps
module smbus_block_register_port_bench;
    localparam logic [6:0] ADDR = smbus_port_pkg::ADDR_SEL1_DEFAULT;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic powerGood = 1'b0;
    logic addressStrapSelect = 1'b1;
    logic smbClk;
    logic hostSda;
    logic sdaOut;
    logic sdaOe_b;
    logic diffOut0Enable;
    logic diffOut1Enable;
    logic sdaWire;
    logic [7:0] expRegs [8];
    int nFail = 0;
    int checked = 0;

    always #20 core_clk = ~core_clk;
    assign sdaWire = hostSda & (sdaOe_b | sdaOut);

    smbus_block_register_port u_dut (
        .core_clk(core_clk), .rst_b(rst_b), .smbClk(smbClk), .sdaIn(sdaWire),
        .sdaOut(sdaOut), .sdaOe_b(sdaOe_b), .addressStrapSelect(addressStrapSelect),
        .powerGood(powerGood), .diffOut0Enable(diffOut0Enable),
        .diffOut1Enable(diffOut1Enable)
    );

    smbus_host_model u_host (.smbClk(smbClk), .hostSda(hostSda), .sdaWire(sdaWire));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            nFail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task finish_test;
        if (nFail == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    task automatic sendByte(input logic [7:0] d, input logic expAck);
        logic ack;
        u_host.byteOut(d, ack);
        check({7'h00, ack}, {7'h00, expAck});
    endtask : sendByte

    task automatic writeBlock(input logic [7:0] n, input logic [7:0] d [$]);
        int k;
        u_host.start();
        sendByte({ADDR, 1'b0}, 1'b1);
        sendByte(n, 1'b1);
        sendByte(8'(d.size()), 1'b1);
        foreach (d[i]) begin
            k = int'(n) + i;
            sendByte(d[i], 1'b1);
            if (k == 0) begin
                expRegs[0] = (d[i] & smbus_port_pkg::OE_WMASK) | ~smbus_port_pkg::OE_WMASK;
            end else if (k < 8) begin
                expRegs[k] = d[i];
            end
        end
        u_host.stop();
    endtask : writeBlock

    task automatic readBlock(input logic [7:0] n);
        int cnt;
        int k;
        logic [7:0] d;
        u_host.start();
        sendByte({ADDR, 1'b0}, 1'b1);
        sendByte(n, 1'b1);
        u_host.start();
        sendByte({ADDR, 1'b1}, 1'b1);
        cnt = int'(expRegs[7]);
        u_host.byteIn(1'b1, d);
        check(d, expRegs[7]);
        for (int i = 0; i < cnt; i++) begin
            k = int'(n) + i;
            u_host.byteIn(i < cnt - 1, d);
            check(d, (k < 8) ? expRegs[k] : 8'hff);
        end
        u_host.stop();
    endtask : readBlock

    task automatic scnPowerUp;
        check({6'h00, diffOut1Enable, diffOut0Enable}, 8'h03);
        check({7'h00, sdaOe_b}, 8'h01);
        u_host.start();
        sendByte({ADDR, 1'b0}, 1'b0);
        u_host.stop();
        @(posedge core_clk) powerGood <= 1'b1;
        repeat (8) @(posedge core_clk);
        addressStrapSelect <= 1'b0;
        repeat (8) @(posedge core_clk);
        u_host.start();
        sendByte({smbus_port_pkg::ADDR_SEL0_DEFAULT, 1'b0}, 1'b0);
        u_host.stop();
    endtask : scnPowerUp

    task automatic scnGates;
        logic [7:0] vals [4] = '{8'h00, 8'h04, 8'h02, 8'h06};
        foreach (vals[i]) begin
            writeBlock(8'h00, '{vals[i]});
            repeat (2) @(posedge core_clk);
            check({6'h00, diffOut1Enable, diffOut0Enable}, {6'h00, vals[i][2:1]});
        end
    endtask : scnGates

    task automatic scnBlocks;
        writeBlock(8'h05, '{8'h5a, 8'ha5, 8'h04});
        writeBlock(8'h01, '{8'h3c, 8'hc3});
        readBlock(8'h00);
        readBlock(8'h05);
        writeBlock(8'h07, '{8'h03, 8'h77});
        readBlock(8'h06);
    endtask : scnBlocks

    initial begin
        foreach (expRegs[i]) begin
            expRegs[i] = smbus_port_pkg::REGS_RESET[i];
        end
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        scnPowerUp();
        scnGates();
        scnBlocks();
        finish_test();
    end

    initial begin
        repeat (100000) @(posedge core_clk);
        nFail++;
        finish_test();
    end
endmodule : smbus_block_register_port_bench

// ==== smbus_host_model.sv ====
// SMBus host model that drives the link clock and the data line.
`timescale 1ns/1ps
module smbus_host_model (
    // Link pins.
    output logic smbClk,
    output logic hostSda,
    // Resolved data wire.
    input wire logic sdaWire
);
    logic tickClk = 1'b0;

    // The link clock stands high between frames; a bit takes five 40 ns ticks, four low, one high.
    // The long low phase lets the port answer through its synchronisers before the next rise.
    initial begin
        smbClk = 1'b1;
        hostSda = 1'b1;
        #13;
        forever #20 tickClk = ~tickClk;
    end

    task automatic tick;
        @(posedge tickClk);
    endtask : tick

    // Start or repeated start: data is set high before the clock rises, then pulled low while the clock is high.
    task automatic start;
        tick();
        hostSda <= 1'b1;
        repeat (3) tick();
        smbClk <= 1'b1;
        tick();
        hostSda <= 1'b0;
        tick();
        smbClk <= 1'b0;
    endtask : start

    // Stop after the last acknowledge slot.
    task automatic stop;
        tick();
        hostSda <= 1'b0;
        repeat (3) tick();
        smbClk <= 1'b1;
        tick();
        hostSda <= 1'b1;
        tick();
    endtask : stop

    // One bit; the wire is sampled at the end of the high phase.
    task automatic bitOut(input logic b, output logic s);
        tick();
        hostSda <= b;
        repeat (3) tick();
        smbClk <= 1'b1;
        tick();
        s = sdaWire;
        smbClk <= 1'b0;
    endtask : bitOut

    task automatic byteOut(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitOut(d[i], s);
        end
        bitOut(1'b1, s);
        ack = ~s;
    endtask : byteOut

    // Reads a byte, then acknowledges it or answers with a not-acknowledge.
    task automatic byteIn(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bitOut(1'b1, s);
            d[i] = s;
        end
        bitOut(~ack, s);
    endtask : byteIn
endmodule : smbus_host_model

// ==== smbus_port_pkg.sv ====
// Shared constants and types of the SMBus register port.
package smbus_port_pkg;

    // Register map.
    localparam int REG_COUNT = 8;
    localparam logic [7:0] OE_REG_IDX = 8'h00;
    localparam logic [7:0] BYTE_COUNT_IDX = 8'h07;

    // Output enable register fields.
    localparam int OE0_BIT = 1;
    localparam int OE1_BIT = 2;
    localparam logic [7:0] OE_WMASK = 8'h06;

    // Values after reset, index 7 first.
    localparam logic [7:0] OE_RESET = 8'hff;
    localparam logic [7:0] BYTE_COUNT_RESET = 8'h08;
    localparam logic [REG_COUNT-1:0][7:0] REGS_RESET = {
        BYTE_COUNT_RESET, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, OE_RESET
    };

    // Bit counting within one byte frame.
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [3:0] ACK_SLOT = 4'h9;

    // Target addresses selected by the strap.
    localparam logic [6:0] ADDR_SEL0_DEFAULT = 7'h50;
    localparam logic [6:0] ADDR_SEL1_DEFAULT = 7'h51;

    // Protocol phases.
    typedef enum logic [2:0] {
        IDLE,
        ADDR,
        INDEX,
        WCOUNT,
        WDATA,
        RCOUNT,
        RDATA,
        SKIP
    } phase_t;

endpackage : smbus_port_pkg
